/* fid_pkg.sv */
// Purpose: shared constants for the flash instruction decoder
// Assumes: 50 MHz system clock, 8-bit host data bus
// Notes:   instruction addresses compare on the low twelve bits only
package fid_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned QUEUE_WINDOW_US = 80;
  // longest time: round down
  localparam int unsigned QUEUE_WINDOW_CYC = (QUEUE_WINDOW_US * (CLK_HZ / 1_000_000));
  localparam int unsigned GAP_DEFAULT_CYC = 2000;

  // ==========================================================
  // instruction addresses and bytes
  // ==========================================================
  localparam int unsigned DEC_ADDR_W = 12;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam logic [11:0] ADDR_IDENT = 12'h001;
  localparam logic [11:0] ADDR_PROT = 12'h002;

  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;

  // ==========================================================
  // read data layout
  // ==========================================================
  localparam int unsigned TOGGLE_FLAG_BIT = 6;
  localparam int unsigned FAILURE_FLAG_BIT = 5;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] STATUS_IDLE = 8'h00;
  localparam logic [7:0] MASK_ALL_MAIN = 8'hFF;
  localparam logic [7:0] MASK_ALL_BOOT = 8'h0F;
  localparam logic [7:0] MASK_NONE = 8'h00;

  // ==========================================================
  // decoder states
  // ==========================================================
  typedef enum logic [3:0] {
    ST_READ = 4'h0,
    ST_CODED1 = 4'h1,
    ST_CODED2 = 4'h2,
    ST_ERASE1 = 4'h3,
    ST_ERASE2 = 4'h4,
    ST_ERASE3 = 4'h5,
    ST_QUEUE = 4'h6,
    ST_PROG = 4'h7,
    ST_BYPASS = 4'h8,
    ST_BYP_PROG = 4'h9,
    ST_BYP_EXIT = 4'hA,
    ST_IDENT = 4'hB,
    ST_BUSY = 4'hC,
    ST_SUSP = 4'hD,
    ST_FAILED = 4'hE
  } fid_state_e;

endpackage : fid_pkg

/* fid_cycle_timer.sv */
// Purpose: reloadable down counter giving a one-cycle expiry pulse
// Assumes: restart may be pulsed at any time; it wins over expiry
// Notes:   idle (count zero) until the first restart after reset
module fid_cycle_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic restart,
  // status
  output logic expired
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  if (CYCLES < 1) begin : g_chk
    $error("fid_cycle_timer: CYCLES must be at least one");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expired;
  } fid_timer_s;

  fid_timer_s tmr_q;
  fid_timer_s tmr_d;

  always_comb begin
    tmr_d = tmr_q;
    tmr_d.expired = 1'b0;
    if (restart) begin
      tmr_d.cnt = LOAD;
    end else if (tmr_q.cnt != '0) begin
      tmr_d.cnt = tmr_q.cnt - ONE;
      tmr_d.expired = (tmr_q.cnt == ONE);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  assign expired = tmr_q.expired;

endmodule : fid_cycle_timer

/* fid_decoder.sv */
// Purpose: decodes host write sequences into flash program/erase instructions
// Assumes: host strobes and selects are synchronous to clk; embedded
//          algorithms live outside and report through engine_done/engine_fail
// Notes:   one decoder serves both arrays; the first coded cycle picks the array for erase, the data cycle for program
//
// Overview of operation
// - ready/busy output low while programming, erasing or a sector erase is queued, high otherwise
// - plain reads outside any sequence return array contents like a ROM
// - host writes never store data; each byte feeds the sequence decoder
// - instruction runs only after all bytes arrive within the gap time-out
// - invalid byte or gap time-out returns decoder to bypass, suspend or read-array mode, whichever it was in
// - outside bypass, all but B0h, 30h resume and F0h start with AAh@555h then 55h@AAAh
// - only the twelve low address bits take part in matching
// - sector selects route each instruction to main or secondary array
// - after 90h, read at offset 01h of main array returns identifier
// - after 90h, read at offset 02h returns sector protection 00h/01h
// - program: coded cycles, A0h@555h, then data at the target location
// - program address taken at strobe fall, data at strobe rise
// - sector erase sequence ends 30h@sector; more sectors within 80us
// - bulk erase sequence ends 10h@555h and erases the whole array
// - B0h suspends a running sector erase; reads and programs allowed
// - 30h resumes only while suspended, otherwise ignored
// - F0h ends identifier and error modes; clears errors unless busy or queued
// - coded cycles plus 20h enter bypass; bypass program is A0h then data
// - bypass leaves on 90h then 00h, back to read-array mode
// - reset puts both arrays in read-array mode
// - reads of busy array show bit 6 inverting on every read
// - failure flag on bit 5 set on failure, cleared by reset instruction
module fid_decoder #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned GAP_CYCLES = fid_pkg::GAP_DEFAULT_CYC,
  parameter logic [7:0] MAIN_IDENT = 8'h5A // arbitrary identifier value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host bus
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] main_sector_select,
  input wire logic [3:0] boot_sector_select,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  output logic ready_busy_pin,
  // array contents and protection
  input wire logic [7:0] main_rdata,
  input wire logic [7:0] boot_rdata,
  input wire logic [7:0] main_protect,
  input wire logic [3:0] boot_protect,
  // embedded algorithm engine
  output logic prog_start,
  output logic erase_start,
  output logic erase_suspend,
  output logic erase_resume,
  output logic op_boot,
  output logic op_bulk,
  output logic [ADDR_W-1:0] program_location,
  output logic [7:0] program_value,
  output logic [7:0] erase_mask,
  input wire logic engine_done,
  input wire logic engine_fail
);

  if (ADDR_W < fid_pkg::DEC_ADDR_W) begin : g_chk_addr
    $error("fid_decoder: ADDR_W must cover the decoded address bits");
  end

  typedef struct packed {
    fid_pkg::fid_state_e state;
    logic wr_prev;
    logic rd_prev;
    logic tgt_boot;
    logic [ADDR_W-1:0] wa;
    logic [7:0] wsel_main;
    logic [3:0] wsel_boot;
    logic bypass;
    logic susp;
    logic fail;
    logic sector_erase;
    logic erase_op;
    logic toggle;
    logic [7:0] rdata;
    logic rdata_oe;
    logic ready;
    logic prog_start;
    logic erase_start;
    logic susp_pulse;
    logic resume_pulse;
    logic op_boot;
    logic op_bulk;
    logic [ADDR_W-1:0] prog_addr;
    logic [7:0] prog_data;
    logic [7:0] mask;
  } fid_dec_s;

  fid_dec_s r_q;
  fid_dec_s r_d;

  logic gap_restart;
  logic gap_expired;
  logic queue_restart;
  logic queue_expired;

  // ==========================================================
  // time-out timers
  // ==========================================================
  // gap length parameter
  fid_cycle_timer #(
    .CYCLES(GAP_CYCLES)
  ) u_gap_timer (
    .clk(clk),
    .rstn(rstn),
    .restart(gap_restart),
    .expired(gap_expired)
  );

  fid_cycle_timer #(
    .CYCLES(fid_pkg::QUEUE_WINDOW_CYC)
  ) u_queue_timer (
    .clk(clk),
    .rstn(rstn),
    .restart(queue_restart),
    .expired(queue_expired)
  );

  // ==========================================================
  // decoder
  // ==========================================================
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic sel_main;
  logic sel_boot;
  logic wsel_any;
  logic same_array;
  logic [11:0] a12;
  logic [7:0] d8;
  logic mid_seq;
  fid_pkg::fid_state_e home;
  logic [7:0] sector_bits;
  logic [7:0] status_byte;
  logic op_selected;

  always_comb begin
    r_d = r_q;
    r_d.prog_start = 1'b0;
    r_d.erase_start = 1'b0;
    r_d.susp_pulse = 1'b0;
    r_d.resume_pulse = 1'b0;
    r_d.wr_prev = wr_n;
    r_d.rd_prev = rd_n;
    wr_fall = r_q.wr_prev & ~wr_n;
    wr_rise = ~r_q.wr_prev & wr_n;
    rd_fall = r_q.rd_prev & ~rd_n;
    sel_main = |main_sector_select;
    sel_boot = |boot_sector_select;
    wsel_any = (|r_q.wsel_main) | (|r_q.wsel_boot);
    same_array = (|r_q.wsel_boot) == r_q.tgt_boot;
    a12 = r_q.wa[fid_pkg::DEC_ADDR_W-1:0];
    d8 = host_wdata;
    sector_bits = r_q.tgt_boot ? {4'h0, r_q.wsel_boot} : r_q.wsel_main;
    gap_restart = 1'b0;
    queue_restart = 1'b0;
    if (r_q.bypass) begin
      home = fid_pkg::ST_BYPASS;
    end else if (r_q.susp) begin
      home = fid_pkg::ST_SUSP;
    end else begin
      home = fid_pkg::ST_READ;
    end
    mid_seq = (r_q.state == fid_pkg::ST_CODED1) || (r_q.state == fid_pkg::ST_CODED2) ||
              (r_q.state == fid_pkg::ST_ERASE1) || (r_q.state == fid_pkg::ST_ERASE2) ||
              (r_q.state == fid_pkg::ST_ERASE3) || (r_q.state == fid_pkg::ST_PROG) ||
              (r_q.state == fid_pkg::ST_BYP_PROG) || (r_q.state == fid_pkg::ST_BYP_EXIT);

    // address and selects at strobe fall
    if (wr_fall) begin
      r_d.wa = host_addr;
      r_d.wsel_main = main_sector_select;
      r_d.wsel_boot = boot_sector_select;
    end

    if (mid_seq && gap_expired) begin
      r_d.state = home;
    end

    // each selected write feeds the decoder, nothing is stored
    if (wr_rise && wsel_any) begin
      gap_restart = 1'b1;
      // reset instruction clears the error flag
      if (d8 == fid_pkg::CMD_RESET && r_q.state != fid_pkg::ST_BUSY && r_q.state != fid_pkg::ST_QUEUE) begin
        r_d.fail = 1'b0;
      end
      case (r_q.state)
        fid_pkg::ST_READ, fid_pkg::ST_SUSP: begin
          // first coded cycle, array chosen by the select
          if (d8 == fid_pkg::CMD_UNLOCK1 && a12 == fid_pkg::ADDR_UNLOCK1) begin
            r_d.state = fid_pkg::ST_CODED1;
            r_d.tgt_boot = |r_q.wsel_boot;
          end else if (r_q.state == fid_pkg::ST_SUSP && d8 == fid_pkg::CMD_RESUME) begin
            r_d.resume_pulse = 1'b1;
            r_d.susp = 1'b0;
            r_d.state = fid_pkg::ST_BUSY;
          end
        end
        fid_pkg::ST_CODED1: begin
          if (d8 == fid_pkg::CMD_UNLOCK2 && a12 == fid_pkg::ADDR_UNLOCK2 && same_array) begin
            r_d.state = fid_pkg::ST_CODED2;
          end else begin
            r_d.state = home;
          end
        end
        fid_pkg::ST_CODED2: begin
          r_d.state = home;
          if (a12 == fid_pkg::ADDR_UNLOCK1 && same_array) begin
            case (d8)
              fid_pkg::CMD_AUTOSEL: r_d.state = fid_pkg::ST_IDENT;
              fid_pkg::CMD_PROGRAM: r_d.state = fid_pkg::ST_PROG;
              fid_pkg::CMD_ERASE_SETUP: begin
                if (!r_q.susp) begin
                  r_d.state = fid_pkg::ST_ERASE1;
                end
              end
              fid_pkg::CMD_BYPASS: begin
                if (!r_q.susp) begin
                  r_d.bypass = 1'b1;
                  r_d.state = fid_pkg::ST_BYPASS;
                end
              end
              default: r_d.state = home;
            endcase
          end
        end
        fid_pkg::ST_ERASE1: begin
          if (d8 == fid_pkg::CMD_UNLOCK1 && a12 == fid_pkg::ADDR_UNLOCK1 && same_array) begin
            r_d.state = fid_pkg::ST_ERASE2;
          end else begin
            r_d.state = home;
          end
        end
        fid_pkg::ST_ERASE2: begin
          if (d8 == fid_pkg::CMD_UNLOCK2 && a12 == fid_pkg::ADDR_UNLOCK2 && same_array) begin
            r_d.state = fid_pkg::ST_ERASE3;
          end else begin
            r_d.state = home;
          end
        end
        fid_pkg::ST_ERASE3: begin
          r_d.state = home;
          if (same_array && d8 == fid_pkg::CMD_SECTOR_ERASE) begin
            r_d.mask = sector_bits;
            r_d.op_boot = r_q.tgt_boot;
            r_d.op_bulk = 1'b0;
            r_d.sector_erase = 1'b1;
            queue_restart = 1'b1;
            r_d.state = fid_pkg::ST_QUEUE;
          end else if (same_array && d8 == fid_pkg::CMD_BULK_ERASE && a12 == fid_pkg::ADDR_UNLOCK1) begin
            r_d.mask = r_q.tgt_boot ? fid_pkg::MASK_ALL_BOOT : fid_pkg::MASK_ALL_MAIN;
            r_d.op_boot = r_q.tgt_boot;
            r_d.op_bulk = 1'b1;
            r_d.sector_erase = 1'b0;
            r_d.erase_op = 1'b1;
            r_d.erase_start = 1'b1;
            r_d.state = fid_pkg::ST_BUSY;
          end
        end
        fid_pkg::ST_QUEUE: begin
          // extra sectors restart the window; other bytes ignored
          if (same_array && d8 == fid_pkg::CMD_SECTOR_ERASE) begin
            r_d.mask = r_q.mask | sector_bits;
            queue_restart = 1'b1;
          end
        end
        fid_pkg::ST_PROG, fid_pkg::ST_BYP_PROG: begin
          // data cycle starts the embedded program
          r_d.prog_addr = r_q.wa;
          r_d.prog_data = d8;
          r_d.op_boot = |r_q.wsel_boot;
          r_d.op_bulk = 1'b0;
          r_d.erase_op = 1'b0;
          r_d.prog_start = 1'b1;
          r_d.state = fid_pkg::ST_BUSY;
        end
        fid_pkg::ST_BYPASS: begin
          if (d8 == fid_pkg::CMD_PROGRAM) begin
            r_d.state = fid_pkg::ST_BYP_PROG;
          end else if (d8 == fid_pkg::CMD_AUTOSEL) begin
            r_d.state = fid_pkg::ST_BYP_EXIT;
          end
        end
        fid_pkg::ST_BYP_EXIT: begin
          if (d8 == fid_pkg::CMD_BYPASS_EXIT) begin
            r_d.bypass = 1'b0;
            r_d.state = r_q.susp ? fid_pkg::ST_SUSP : fid_pkg::ST_READ;
          end else begin
            r_d.state = fid_pkg::ST_BYPASS;
          end
        end
        fid_pkg::ST_IDENT, fid_pkg::ST_FAILED: begin
          // reset instruction ends identifier and error modes
          if (d8 == fid_pkg::CMD_RESET) begin
            r_d.state = home;
          end
        end
        fid_pkg::ST_BUSY: begin
          // suspend only a running sector erase
          if (d8 == fid_pkg::CMD_SUSPEND && r_q.erase_op && r_q.sector_erase && !r_q.susp) begin
            r_d.susp_pulse = 1'b1;
            r_d.susp = 1'b1;
            r_d.state = fid_pkg::ST_SUSP;
          end
        end
        default: r_d.state = fid_pkg::ST_READ;
      endcase
    end

    // queue closes once the window runs out
    if (r_q.state == fid_pkg::ST_QUEUE && queue_expired) begin
      r_d.erase_op = 1'b1;
      r_d.erase_start = 1'b1;
      r_d.state = fid_pkg::ST_BUSY;
    end

    // completion; a failure holds until the reset instruction
    if (r_q.state == fid_pkg::ST_BUSY && engine_done) begin
      if (engine_fail) begin
        r_d.fail = 1'b1;
        r_d.susp = 1'b0;
        r_d.state = fid_pkg::ST_FAILED;
      end else if (r_q.erase_op) begin
        r_d.susp = 1'b0;
        r_d.state = r_q.bypass ? fid_pkg::ST_BYPASS : fid_pkg::ST_READ;
      end else begin
        r_d.state = home;
      end
    end

    // ==========================================================
    // read path
    // ==========================================================
    op_selected = r_q.op_boot ? sel_boot : sel_main;
    status_byte = fid_pkg::STATUS_IDLE;
    status_byte[fid_pkg::TOGGLE_FLAG_BIT] = r_q.toggle;
    status_byte[fid_pkg::FAILURE_FLAG_BIT] = r_q.fail;
    // toggle flips on every read of the busy array
    if (rd_fall && op_selected && (r_q.state == fid_pkg::ST_BUSY || r_q.state == fid_pkg::ST_QUEUE)) begin
      r_d.toggle = ~r_q.toggle;
    end
    r_d.rdata_oe = ~rd_n & (sel_main | sel_boot);
    if (r_q.state == fid_pkg::ST_IDENT && host_addr[fid_pkg::DEC_ADDR_W-1:0] == fid_pkg::ADDR_IDENT) begin
      // main array only; secondary reads as no identifier
      r_d.rdata = sel_main ? MAIN_IDENT : fid_pkg::STATUS_IDLE;
    end else if (r_q.state == fid_pkg::ST_IDENT && host_addr[fid_pkg::DEC_ADDR_W-1:0] == fid_pkg::ADDR_PROT) begin
      r_d.rdata = (|(main_sector_select & main_protect)) || (|(boot_sector_select & boot_protect)) ?
                  fid_pkg::PROT_YES : fid_pkg::PROT_NO;
    end else if (op_selected && (r_q.state == fid_pkg::ST_BUSY || r_q.state == fid_pkg::ST_QUEUE ||
                                 r_q.state == fid_pkg::ST_FAILED)) begin
      r_d.rdata = status_byte;
    end else if (sel_boot) begin
      r_d.rdata = boot_rdata;
    end else begin
      r_d.rdata = main_rdata;
    end

    // busy while an operation runs or is queued
    r_d.ready = !(r_d.state == fid_pkg::ST_BUSY || r_d.state == fid_pkg::ST_QUEUE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
      r_q.state <= fid_pkg::ST_READ;
      r_q.wr_prev <= 1'b1;
      r_q.rd_prev <= 1'b1;
      r_q.ready <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign host_rdata = r_q.rdata;
  assign host_rdata_oe = r_q.rdata_oe;
  assign ready_busy_pin = r_q.ready;
  assign prog_start = r_q.prog_start;
  assign erase_start = r_q.erase_start;
  assign erase_suspend = r_q.susp_pulse;
  assign erase_resume = r_q.resume_pulse;
  assign op_boot = r_q.op_boot;
  assign op_bulk = r_q.op_bulk;
  assign program_location = r_q.prog_addr;
  assign program_value = r_q.prog_data;
  assign erase_mask = r_q.mask;

endmodule : fid_decoder

/* fid_decoder_monitor.sv */
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock domain, async active-low reset
// Notes:   attached by bind at the foot of this file
module fid_decoder_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host side
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] main_sector_select,
  input wire logic [3:0] boot_sector_select,
  input wire logic host_rdata_oe,
  input wire logic ready_busy_pin,
  // engine side
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic erase_suspend,
  input wire logic erase_resume,
  input wire logic [7:0] program_value,
  input wire logic engine_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // sequences and properties
  // ==========================================================
  // a byte was decoded on the previous edge
  sequence s_decoded;
    $past(wr_n) && !$past(wr_n, 2);
  endsequence
  property p_busy_on_start;
    (prog_start || erase_start) |-> !ready_busy_pin;
  endproperty
  // suspend may free the pin, so it counts as a cause too
  property p_ready_cause;
    $rose(ready_busy_pin) |-> $past(engine_done) || $past(erase_suspend) || erase_suspend;
  endproperty
  property p_oe_follows_read;
    1 |=> host_rdata_oe == (!$past(rd_n) && ((|$past(main_sector_select)) || (|$past(boot_sector_select))));
  endproperty
  property p_one_pulse;
    $onehot0({prog_start, erase_start, erase_suspend, erase_resume});
  endproperty
  property p_prog_single;
    prog_start |=> !prog_start;
  endproperty
  property p_pulse_after_rise;
    (prog_start || erase_suspend || erase_resume) |-> s_decoded;
  endproperty
  property p_prog_value;
    prog_start |-> program_value == $past(host_wdata);
  endproperty
  property p_suspend_byte;
    erase_suspend |-> $past(host_wdata) == fid_pkg::CMD_SUSPEND;
  endproperty
  property p_resume_byte;
    erase_resume |-> $past(host_wdata) == fid_pkg::CMD_RESUME;
  endproperty
  // ==========================================================
  // assertions
  // ==========================================================
  a_busy_on_start: assert property (p_busy_on_start) else $error("ready high at op start");
  a_ready_cause: assert property (p_ready_cause) else $error("ready rose without cause");
  a_oe_follows_read: assert property (p_oe_follows_read) else $error("read enable wrong");
  a_one_pulse: assert property (p_one_pulse) else $error("two engine pulses at once");
  a_prog_single: assert property (p_prog_single) else $error("program pulse too long");
  a_pulse_after_rise: assert property (p_pulse_after_rise) else $error("pulse not after strobe rise");
  a_prog_value: assert property (p_prog_value) else $error("program data not from strobe rise");
  a_suspend_byte: assert property (p_suspend_byte) else $error("suspend on wrong byte");
  a_resume_byte: assert property (p_resume_byte) else $error("resume on wrong byte");
endmodule : fid_decoder_monitor

bind fid_decoder fid_decoder_monitor mon_u (.*);

/* fid_engine_model.sv */
// Purpose: behavioural embedded-algorithm engine beside the decoder
// Assumes: starts are one-cycle pulses
// Notes:   fixed latencies; suspend freezes the countdown
module fid_engine_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // requests
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic erase_suspend,
  input wire logic erase_resume,
  input wire logic fail_next,
  // answers
  output logic engine_done,
  output logic engine_fail
);
  logic [8:0] cnt_q;
  logic hold_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 9'h0;
      hold_q <= 1'b0;
      engine_done <= 1'b0;
      engine_fail <= 1'b0;
    end else begin
      engine_done <= 1'b0;
      if (prog_start) cnt_q <= 9'h28;
      else if (erase_start) cnt_q <= 9'h12C;
      else if (erase_suspend) hold_q <= 1'b1;
      else if (erase_resume) hold_q <= 1'b0;
      else if (cnt_q != 9'h0 && !hold_q) begin
        cnt_q <= cnt_q - 9'h1;
        if (cnt_q == 9'h1) begin
          engine_done <= 1'b1;
          engine_fail <= fail_next;
        end
      end
    end
  end
endmodule : fid_engine_model

/* fid_tb.sv */
// Purpose: self-checking bench for the instruction decoder
// Assumes: short gap time-out of 8 cycles
// Notes:   program and erase start pulses are checked against a queue of notes
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr_n, rd_n, host_rdata_oe, ready_busy_pin, fail_next;
  logic [15:0] host_addr, program_location, pa;
  logic [7:0] host_wdata, main_sector_select, host_rdata, main_rdata, boot_rdata, main_protect;
  logic [7:0] erase_mask, program_value, v, w, d;
  logic [3:0] boot_sector_select, boot_protect;
  logic prog_start, erase_start, erase_suspend, erase_resume, op_boot, op_bulk, engine_done, engine_fail;
  logic [24:0] exp_q[$], got;
  int err_total, cmp_count;
  localparam logic [11:0] sel_m = 12'h001;
  localparam logic [11:0] sel_b = 12'h100;
  fid_decoder #(.GAP_CYCLES(8), .MAIN_IDENT(8'hC3)) dut_u (.*);
  fid_engine_model eng_u (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
  // ==========================================================
  // tasks
  // ==========================================================
  task check(input logic [24:0] seen, input logic [24:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task wr(input logic [15:0] a, input logic [7:0] dv, input logic [11:0] s);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= dv;
    {boot_sector_select, main_sector_select} <= s;
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    {boot_sector_select, main_sector_select} <= 12'h0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [11:0] s, output logic [7:0] r);
    @(posedge clk);
    host_addr <= a;
    {boot_sector_select, main_sector_select} <= s;
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    r = host_rdata;
    rd_n <= 1'b1;
    {boot_sector_select, main_sector_select} <= 12'h0;
  endtask : rd
  // random upper address bits must not matter
  task cmd(input logic [11:0] s, input logic [7:0] c);
    wr({4'($urandom), 12'h555}, 8'hAA, s);
    wr({4'($urandom), 12'hAAA}, 8'h55, s);
    if (c != 8'hFF) wr(16'h0555, c, s);
  endtask : cmd
  task wait_rdy();
    for (int i = 0; i < 1000 && ready_busy_pin !== 1'b1; i++) @(posedge clk);
  endtask : wait_rdy
  always @(posedge clk) begin
    if (prog_start === 1'b1 || erase_start === 1'b1) begin
      got = prog_start ? {op_boot, program_location, program_value} : {op_boot, 15'h0, op_bulk, erase_mask};
      if (exp_q.size() == 0) check(got, ~got);
      else check(got, exp_q.pop_front());
    end
  end
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    {rstn, rd_n, wr_n, fail_next, host_addr, host_wdata} = {3'b011, 1'b0, 24'h0};
    {boot_sector_select, main_sector_select, boot_protect, main_protect} = {16'h0, 8'h3C};
    void'($urandom(32'h5e54c256));
    main_rdata = $urandom;
    boot_rdata = $urandom;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    check(ready_busy_pin, 1);
    rd(16'h1234, sel_m, v);
    check(v, main_rdata);
    rd(16'h1234, sel_b, v);
    check(v, boot_rdata);
    d = $urandom;
    pa = $urandom;
    exp_q.push_back({1'b0, pa, d});
    cmd(sel_m, fid_pkg::CMD_PROGRAM);
    wr(pa, d, sel_m);
    check(ready_busy_pin, 0);
    rd(pa, sel_m, v);
    rd(pa, sel_m, w);
    check(v[6] ^ w[6], 1);
    wait_rdy();
    check(ready_busy_pin, 1);
    cmd(sel_m, 8'h77);
    wr(16'h0555, fid_pkg::CMD_PROGRAM, sel_m);
    wr(pa, d, sel_m);
    cmd(sel_m, 8'hFF);
    repeat (20) @(posedge clk);
    wr(16'h0555, fid_pkg::CMD_PROGRAM, sel_m);
    wr(pa, d, sel_m);
    cmd(sel_m, fid_pkg::CMD_AUTOSEL);
    rd({4'hF, fid_pkg::ADDR_IDENT}, sel_m, v);
    check(v, 8'hC3);
    for (int k = 0; k < 8; k++) begin
      rd({4'h0, fid_pkg::ADDR_PROT}, 12'(1 << k), v);
      check(v, {7'h0, main_protect[k]});
    end
    wr(16'h7777, fid_pkg::CMD_RESET, sel_m);
    rd(16'h0002, sel_m, v);
    check(v, main_rdata);
    cmd(sel_m, fid_pkg::CMD_BYPASS);
    exp_q.push_back({1'b0, pa, ~d});
    wr(16'h3210, fid_pkg::CMD_PROGRAM, sel_m);
    wr(pa, ~d, sel_m);
    wait_rdy();
    wr(16'h0123, fid_pkg::CMD_AUTOSEL, sel_m);
    wr(16'h0456, fid_pkg::CMD_BYPASS_EXIT, sel_m);
    wr(16'h3210, fid_pkg::CMD_PROGRAM, sel_m);
    wr(pa, d, sel_m);
    exp_q.push_back({1'b1, 15'h0, 1'b0, 8'h05});
    cmd(sel_b, fid_pkg::CMD_ERASE_SETUP);
    cmd(sel_b, 8'hFF);
    wr(16'h2000, fid_pkg::CMD_SECTOR_ERASE, 12'h400);
    wr(16'h0000, fid_pkg::CMD_SECTOR_ERASE, sel_b);
    for (int i = 0; i < 5000 && erase_start !== 1'b1; i++) @(posedge clk);
    wr(16'h0999, fid_pkg::CMD_SUSPEND, sel_b);
    check(ready_busy_pin, 1);
    rd(16'h0042, sel_m, v);
    check(v, main_rdata);
    wr(16'h0888, fid_pkg::CMD_RESUME, sel_b);
    check(ready_busy_pin, 0);
    wait_rdy();
    check(ready_busy_pin, 1);
    fail_next <= 1'b1;
    exp_q.push_back({1'b0, 15'h0, 1'b1, fid_pkg::MASK_ALL_MAIN});
    cmd(sel_m, fid_pkg::CMD_ERASE_SETUP);
    cmd(sel_m, fid_pkg::CMD_BULK_ERASE);
    wait_rdy();
    rd(16'h0010, sel_m, v);
    check(v & 8'hBF, 8'h20);
    wr(16'h0010, fid_pkg::CMD_RESET, sel_m);
    rd(16'h0010, sel_m, v);
    check(v, main_rdata);
    check(25'(exp_q.size()), 25'h0);
    give_verdict();
  end
endmodule : tb
